// ---- i2c_flag_defines.svh ----
// Register indices, field positions, reset values and bit-count marks
// for the I2C status and bus-flag block. Definitions only.
`ifndef I2C_FLAG_DEFINES_SVH
`define I2C_FLAG_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_BUS_FLAGS 16'hFFA9
`define IDX_XFER_STATUS 16'hFFAA
`define IDX_CONTROL 16'hFFA6
`define IDX_SLAVE_ADDR 16'hFFAB
`define IDX_TX_DATA 16'hFFAC
`define IDX_IRQ_STATUS 16'hFFAD
`define IDX_IRQ_MASK 16'hFFAE

// Bus flag register fields
`define FLG_START_TRIGGER_FAILED_FLAG 7
`define FLG_BUSY 6
`define FLG_ISE 1
`define FLG_RSV 0

// Control register fields
`define CTL_ENABLE 7
`define CTL_EXIT 6
`define CTL_WCANCEL 5
`define CTL_START 1

// Interrupt event fields
`define IRQ_W 5
`define IRQ_START 0
`define IRQ_STOP 1
`define IRQ_ALD 2
`define IRQ_MATCH 3
`define IRQ_BYTE 4

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// Bit count marks within a byte
`define CNT_IDLE 4'h0
`define CNT_FIRST 4'h1
`define CNT_DIR 4'h8
`define CNT_ACK 4'h9

`endif

// ---- i2c_flag_pkg.sv ----
// Types shared by the I2C status and bus-flag block.
// Assumes i2c_flag_defines.svh is on the include path.
package i2c_flag_pkg;
  // Whole register state of the block
  typedef struct packed {
    logic scl_m, sda_m, scl_s, sda_s, scl_p, sda_p;
    logic en, start_trig, ise, rsv, start_trigger_failed_flag, busy;
    logic mst, ald, exc, coi, trc, ackd, std, spd;
    logic [3:0] cnt;
    logic first, drive_en, gen_hold, sda_oe_n;
    logic [7:0] rx, latch, txd;
    logic [6:0] saddr;
    logic [4:0] irq_st, irq_mk;
    logic a_val, a_wr;
    logic [15:0] a_idx;
    logic [31:0] hrdata;
  } flag_state_s;
endpackage : i2c_flag_pkg

// ---- i2c_status_flag_logic.sv ----
// Status and bus-flag logic of an I2C interface with an AHB-Lite slave.
// Assumes a 25 MHz hclk, an external pull-up on SDA, and SCL driven by
// whoever clocks the bus; this block watches SCL and never drives it.
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"

module i2c_status_flag_logic
  import i2c_flag_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);

  flag_state_s q, d;

  ////////////////////////////////////////////////////////////////////////
  // Event decode from synchronised pins
  logic rise, fall, start_det, stop_det;
  logic [3:0] nc;
  logic [7:0] rx_full;

  always_comb
  begin
    rise = q.en & q.scl_s & ~q.scl_p;
    fall = q.en & ~q.scl_s & q.scl_p;
    // SDA moving while SCL stays high marks start or stop
    start_det = q.en & q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_det = q.en & q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    nc = (q.cnt == `CNT_ACK) ? `CNT_FIRST : q.cnt + 4'h1;
    rx_full = {q.rx[6:0], q.sda_s};
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states so the address phase fixes the answer
  logic addr_ok, wr_ok, rd_take, wr_en, ald_event;
  logic [15:0] ra_idx;
  logic [31:0] rd_val;
  logic [7:0] status_byte, flags_byte, ctl_byte;

  always_comb
  begin
    ra_idx = haddr[17:2];
    addr_ok = hsel & htrans[1] & hready & (haddr[1:0] == 2'b00);
    rd_take = addr_ok & ~hwrite;
    wr_ok = q.a_val & q.a_wr;
    status_byte = {q.mst, q.ald, q.exc, q.coi, q.trc, q.ackd, q.std, q.spd};
    flags_byte = {q.start_trigger_failed_flag, q.busy, 4'h0, q.ise, q.rsv};
    ctl_byte = {q.en, 5'h00, q.start_trig, 1'b0};
    case (ra_idx)
      `IDX_BUS_FLAGS: rd_val = {24'h00_0000, flags_byte};
      `IDX_XFER_STATUS: rd_val = {24'h00_0000, status_byte};
      `IDX_CONTROL: rd_val = {24'h00_0000, ctl_byte};
      `IDX_SLAVE_ADDR: rd_val = {24'h00_0000, q.saddr, 1'b0};
      `IDX_TX_DATA: rd_val = {24'h00_0000, q.txd};
      `IDX_IRQ_STATUS: rd_val = {27'h000_0000, q.irq_st};
      `IDX_IRQ_MASK: rd_val = {27'h000_0000, q.irq_mk};
      default: rd_val = `RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: sets first, then clears, so clears win
  always_comb
  begin
    d = q;
    ald_event = 1'b0;
    wr_en = 1'b0;
    // Two-stage synchronisers, third stage for edges
    // Pins belong to no clock here, so stage one feeds no logic; stages two and three do
    d.scl_m = scl_in;
    d.sda_m = sda_in;
    d.scl_s = q.scl_m;
    d.sda_s = q.sda_m;
    d.scl_p = q.scl_s;
    d.sda_p = q.sda_s;
    // Address phase capture
    d.a_val = addr_ok;
    d.a_wr = hwrite;
    d.a_idx = ra_idx;
    if (rd_take)
      d.hrdata = rd_val;

    // Register writes in the data phase
    if (wr_ok)
    begin
      case (q.a_idx)
        `IDX_CONTROL:
        begin
          d.en = hwdata[`CTL_ENABLE];
          wr_en = hwdata[`CTL_ENABLE] & ~q.en;
          if (hwdata[`CTL_START] & q.en)
          begin
            if (q.busy & q.rsv & ~q.mst)
            begin
              d.start_trigger_failed_flag = 1'b1;
              d.start_trig = 1'b0;
            end
            else
            begin
              d.start_trig = 1'b1;
              d.start_trigger_failed_flag = 1'b0;
            end
          end
        end
        `IDX_BUS_FLAGS:
          if (~q.en)
          begin
            d.ise = hwdata[`FLG_ISE];
            d.rsv = hwdata[`FLG_RSV];
          end
        `IDX_SLAVE_ADDR: d.saddr = hwdata[7:1];
        `IDX_TX_DATA: d.txd = hwdata[7:0];
        `IDX_IRQ_STATUS: d.irq_st = q.irq_st & ~hwdata[4:0];
        `IDX_IRQ_MASK: d.irq_mk = hwdata[4:0];
        default: d.en = q.en;
      endcase
    end
    // Enabling with initial-start off assumes a foreign transfer
    if (wr_en & ~q.ise)
      d.busy = 1'b1;

    // Start generation once the bus is free
    // No restart: a pending trigger simply waits for the bus to free up
    if (q.start_trig & q.en & ~q.busy & ~q.gen_hold & q.scl_s & q.sda_s)
      d.gen_hold = 1'b1;

    // Start and stop conditions
    if (start_det)
    begin
      d.std = 1'b1;
      d.busy = 1'b1;
      d.ise = 1'b0;
      d.cnt = `CNT_IDLE;
      d.first = 1'b1;
      d.latch = q.txd;
      d.exc = 1'b0;
      d.coi = 1'b0;
      if (q.gen_hold)
      begin
        d.mst = 1'b1;
        d.trc = 1'b1;
        d.start_trig = 1'b0;
      end
      else
        d.trc = 1'b0;
    end
    if (stop_det)
      d.spd = 1'b1;

    // Rising SCL: count, sample, detect loss
    if (rise)
    begin
      d.cnt = nc;
      d.rx = rx_full;
      if (nc == `CNT_FIRST)
      begin
        d.ackd = 1'b0;
        if (~q.first)
          d.std = 1'b0;
        if (q.first & q.spd)
          d.spd = 1'b0;
      end
      // Loss only on bits 1 to 8 of any byte; the ack slot is the
      // receiver's, and bit 1 of a data byte follows a count of nine
      if (q.mst & q.trc & q.drive_en & q.latch[7] & ~q.sda_s
          & (nc < `CNT_ACK))
      begin
        ald_event = 1'b1;
        d.ald = 1'b1;
      end
      if (q.first & (nc == `CNT_DIR))
      begin
        if ((rx_full[7:4] == 4'h0) | (rx_full[7:4] == 4'hF))
          d.exc = 1'b1;
        if (rx_full[7:1] == q.saddr)
          d.coi = 1'b1;
        if (q.mst)
          d.trc = ~q.latch[7];
        else
          d.trc = q.sda_s;
      end
      if ((nc == `CNT_ACK) & ~q.sda_s)
        d.ackd = 1'b1;
    end

    // Falling SCL: move the output latch
    if (fall)
    begin
      d.gen_hold = 1'b0;
      case (q.cnt)
        `CNT_ACK:
        begin
          d.first = 1'b0;
          d.latch = q.txd;
          d.drive_en = 1'b1;
        end
        `CNT_DIR: d.drive_en = 1'b0;
        `CNT_IDLE: d.drive_en = 1'b1;
        default:
        begin
          d.latch = {q.latch[6:0], 1'b1};
          d.drive_en = 1'b1;
        end
      endcase
    end

    // Sticky events; set beats write-one-to-clear
    if (start_det)
      d.irq_st[`IRQ_START] = 1'b1;
    if (stop_det)
      d.irq_st[`IRQ_STOP] = 1'b1;
    if (ald_event)
      d.irq_st[`IRQ_ALD] = 1'b1;
    if (d.coi & ~q.coi)
      d.irq_st[`IRQ_MATCH] = 1'b1;
    if (fall & (q.cnt == `CNT_ACK))
      d.irq_st[`IRQ_BYTE] = 1'b1;

    // Clears, which win over any set above
    if (ald_event)
    begin
      d.mst = 1'b0;
      d.trc = 1'b0;
      d.start_trig = 1'b0;
    end
    // Read data was captured above, so software sees an earlier loss; one set in the read's own cycle is cleared unseen
    if (rd_take & (ra_idx == `IDX_XFER_STATUS))
      d.ald = 1'b0;
    if (stop_det)
    begin
      {d.mst, d.exc, d.coi, d.trc, d.ackd, d.std} = 6'h00;
      d.busy = 1'b0;
    end
    if (wr_ok & (q.a_idx == `IDX_CONTROL) & hwdata[`CTL_EXIT])
    begin
      {d.mst, d.exc, d.coi, d.trc, d.ackd, d.std} = 6'h00;
      d.start_trig = 1'b0;
      d.gen_hold = 1'b0;
    end
    if (wr_ok & (q.a_idx == `IDX_CONTROL) & hwdata[`CTL_WCANCEL])
      d.trc = 1'b0;
    if (~d.en)
    begin
      d.ald = 1'b0;
      {d.mst, d.exc, d.coi, d.trc, d.ackd, d.std, d.spd} = 7'h00;
      d.start_trigger_failed_flag = 1'b0;
      d.busy = 1'b0;
      d.start_trig = 1'b0;
      d.gen_hold = 1'b0;
      d.cnt = `CNT_IDLE;
    end
    // Pull SDA only for own start or a zero bit while transmitting
    d.sda_oe_n = ~(d.gen_hold | (d.trc & d.drive_en & ~d.latch[7]));
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; pins idle high at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.sda_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.sda_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.latch <= `RST_BYTE;
    end
    else
      q <= d;
  end

  // Outputs
  // SDA is open drain: the pin only ever pulls low, the pull-up gives
  // the one; zero wait states keep the bus side trivially ready
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign sda_out = 1'b0;
  assign sda_oe_n = q.sda_oe_n;
  assign irq = |(q.irq_st & q.irq_mk);

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_master_stop_clear: assert property (stop_det |=> !q.mst)
    else $error("master flag survived a stop");
  a_loss_drops_master: assert property (
    $rose(q.ald) |-> !q.mst && !q.trc)
    else $error("loss left master or transmit set");
  a_loss_read_clear: assert property (
    rd_take && ra_idx == `IDX_XFER_STATUS ##1 !rise |-> !q.ald)
    else $error("loss flag not cleared by status read");
  a_ext_eighth: assert property ($rose(q.exc) |-> q.cnt == `CNT_DIR)
    else $error("extension flag set off the eighth clock");
  a_match_first: assert property ($rose(q.coi) |-> q.first)
    else $error("address match outside address byte");
  a_release_rx: assert property (!q.trc && !q.gen_hold |-> sda_oe_n)
    else $error("SDA driven while receiving");
  a_cancel_trc: assert property (
    wr_ok && q.a_idx == `IDX_CONTROL && hwdata[`CTL_WCANCEL]
    |=> !q.trc ##1 sda_oe_n)
    else $error("wait cancel kept transmit");
  a_ack_ninth: assert property (
    rise && nc == `CNT_ACK && !q.sda_s && !$rose(q.en) |=> q.ackd)
    else $error("ack not seen at ninth rise");
  a_busy_start: assert property (start_det |=> q.busy [*2])
    else $error("busy not set by start");
  a_start_trigger_failed_flag_drop: assert property ($rose(q.start_trigger_failed_flag) |-> !q.start_trig)
    else $error("failed start kept trigger");
  a_disable_clear: assert property ($fell(q.en) |-> status_byte == 8'h00
    && !q.busy && !q.start_trigger_failed_flag)
    else $error("disable left flags set");
  a_ro_flags: assert property (
    q.en && wr_ok && q.a_idx == `IDX_BUS_FLAGS |=> $stable({q.ise, q.rsv}))
    else $error("config bits written while enabled");

  // Flag sets and clears that the bus scenarios walk through
  a_start_flag: assert property (start_det |=> q.std)
    else $error("start flag not set by start");
  a_stop_flag: assert property (stop_det |=> q.spd)
    else $error("stop flag not set by stop");
  a_own_start: assert property (
    start_det && q.gen_hold |=> q.mst && q.trc)
    else $error("own start did not make master");
  a_start_ise: assert property (start_det |=> !q.ise)
    else $error("initial-start enable survived a start");
  a_exit_clear: assert property (
    wr_ok && q.a_idx == `IDX_CONTROL && hwdata[`CTL_EXIT]
    |=> !q.mst && !q.trc && !q.std)
    else $error("exit left master, transmit or start set");

  c_start_seen: cover property (start_det ##1 q.std);
  c_loss_seen: cover property ($rose(q.ald));
  c_match_seen: cover property ($rose(q.coi) ##[1:600] q.ackd);
  c_fail_seen: cover property ($rose(q.start_trigger_failed_flag));
  c_cancel_seen: cover property ($fell(q.trc) && !q.mst);

endmodule : i2c_status_flag_logic

// ---- i2c_bus_partner.sv ----
// Far side of the I2C bus: another master that frames and clocks bytes.
// Assumes the bench resolves the wired-AND SDA with a pull-up.
`timescale 1ns/100ps

module i2c_bus_partner
(
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Idle bus: both lines released, SCL stands high outside frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start: SDA falls while SCL high; odd delay keeps pins off hclk edges
  task start_cond;
    #170 sda_low = 1'b1;
    #160 scl = 1'b0;
  endtask : start_cond

  // Lower SCL after a start that the block made itself
  task clock_low;
    #170 scl = 1'b0;
  endtask : clock_low

  // Nine bits MSB first, 320 ns each; seen is the wire at each rise
  task xfer(input logic [8:0] bits, output logic [8:0] seen);
    for (int i = 8; i >= 0; i--)
    begin
      #20 sda_low = ~bits[i];
      #140 scl = 1'b1;
      #80 seen[i] = sda;
      #80 scl = 1'b0;
    end
  endtask : xfer

  // Stop: SDA low under low SCL, SCL up, then SDA released
  task stop_cond;
    #20 sda_low = 1'b1;
    #140 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask : stop_cond
endmodule : i2c_bus_partner

// ---- i2c_status_flag_logic_tb_top.sv ----
// Self-checking bench: AHB-Lite master tasks and an I2C partner model.
// Assumes hreadyout feeds hready and SDA has a pull-up.
`timescale 1ns/100ps
`include "i2c_flag_defines.svh"

module i2c_status_flag_logic_tb_top;
  localparam logic [6:0] saddr = 7'h35;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic sda_out, sda_oe_n, scl, sda_low, sda_wire;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] corner [4] = '{8'h10, 8'h6b, 8'h01, 8'hf0};
  int n_mismatch = 0;
  int n_checks = 0;

  // Wired AND of the open-drain SDA drivers
  assign sda_wire = (!sda_oe_n || sda_low) ? 1'b0 : 1'b1;

  i2c_status_flag_logic i2c_status_flag_logic_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
  i2c_bus_partner i2c_bus_partner_i (.scl(scl), .sda_low(sda_low),
    .sda(sda_wire));

  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Bounded wait for hready at a rising edge
  task hwait;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      n_mismatch++;
      test_done();
    end
  endtask : hwait

  // One single-word transfer, entered just after a rising edge
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'b00};
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    hwait();
    rd = hrdata;
  endtask : bus

  task wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr

  task rchk(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, {24'h00_0000, e});
    chk({31'h0, hresp}, 32'h0);
  endtask : rchk

  task settle;
    repeat (6) @(posedge hclk);
  endtask : settle

  // Slave-side frame: address byte, acked by a third party, a data byte in frame 0 only, then stop
  task frame(input logic [7:0] b, input int idx);
    logic [8:0] seen;
    logic [7:0] e;
    e = {2'b00, (b[7:4] == 4'h0) || (b[7:4] == 4'hf), b[7:1] == saddr,
      b[0], 3'b110};
    i2c_bus_partner_i.start_cond();
    i2c_bus_partner_i.xfer({b, 1'b0}, seen);
    settle();
    rchk(`IDX_XFER_STATUS, e);
    if (idx == 0)
    begin
      i2c_bus_partner_i.xfer(9'h1ff, seen);
      settle();
      rchk(`IDX_XFER_STATUS, 8'h00);
    end
    else if (b[0])
    begin
      chk({31'h0, sda_oe_n}, 32'h0);
      wr(`IDX_CONTROL, 8'ha0);
      settle();
      rchk(`IDX_XFER_STATUS, e & 8'hf7);
      chk({31'h0, sda_oe_n}, 32'h1);
    end
    else
    begin
      wr(`IDX_CONTROL, 8'hc0);
      settle();
      rchk(`IDX_XFER_STATUS, 8'h00);
    end
    i2c_bus_partner_i.stop_cond();
    settle();
    rchk(`IDX_XFER_STATUS, 8'h01);
    rchk(`IDX_BUS_FLAGS, 8'h00);
  endtask : frame

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [8:0] seen;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize = 3'b010;
    rnd = 32'h178b_13ec;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`IDX_XFER_STATUS, 8'h00);
    rchk(`IDX_BUS_FLAGS, 8'h00);
    rchk(16'h0001, 8'h00);
    chk({31'h0, sda_out}, 32'h0);
    wr(`IDX_SLAVE_ADDR, {saddr, 1'b0});
    wr(`IDX_TX_DATA, 8'h7f);
    wr(`IDX_IRQ_MASK, 8'h01);
    wr(`IDX_CONTROL, 8'h80);
    rchk(`IDX_BUS_FLAGS, 8'h40);
    wr(`IDX_BUS_FLAGS, 8'h03);
    rchk(`IDX_BUS_FLAGS, 8'h40);
    // Corner addresses first, then random ones
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      frame(i < 4 ? corner[i] : rnd[7:0], i);
    end
    chk({31'h0, irq}, 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h1f);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    // Own start as master, address byte sent, then arbitration lost at the first bit of the next byte
    wr(`IDX_TX_DATA, 8'ha0);
    wr(`IDX_CONTROL, 8'h82);
    repeat (10) @(posedge hclk);
    rchk(`IDX_XFER_STATUS, 8'h8b);
    i2c_bus_partner_i.clock_low();
    i2c_bus_partner_i.xfer(9'h1fe, seen);
    chk({24'h0, seen[8:1]}, 32'h0000_00a0);
    settle();
    rchk(`IDX_XFER_STATUS, 8'h8e);
    i2c_bus_partner_i.stop_cond();
    settle();
    rchk(`IDX_XFER_STATUS, 8'h41);
    rchk(`IDX_XFER_STATUS, 8'h01);
    wr(`IDX_CONTROL, 8'h00);
    rchk(`IDX_XFER_STATUS, 8'h00);
    // Start refused while busy with reservation on
    wr(`IDX_BUS_FLAGS, 8'h01);
    wr(`IDX_CONTROL, 8'h80);
    wr(`IDX_CONTROL, 8'h82);
    settle();
    rchk(`IDX_BUS_FLAGS, 8'hc1);
    rchk(`IDX_CONTROL, 8'h80);
    wr(`IDX_CONTROL, 8'h00);
    rchk(`IDX_BUS_FLAGS, 8'h01);
    wr(`IDX_BUS_FLAGS, 8'hff);
    rchk(`IDX_BUS_FLAGS, 8'h03);
    wr(`IDX_CONTROL, 8'h80);
    rchk(`IDX_BUS_FLAGS, 8'h03);
    test_done();
  end
endmodule : i2c_status_flag_logic_tb_top
